//--- dv/master_clock_generation_tb.sv
`timescale 1ns/1ps
module master_clock_generation_tb;
    import clock_gen_pkg::*;
    logic mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00, per = 8'h04;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, mc, cpu, sys, osc, err;
    int n_errors = 0, cmp_count = 0, cyc = 0, mc_n = 0, cpu_n = 0;
    always #2.5 mclk = ~mclk;
    clock_gen dut_u (.mclk_in(mclk), .rst_n_in(rst_n), .ce_in(ce), .osc_tick_in(osc), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
        .prdata_out(prdata), .pslverr_out(pslverr), .mc_tick_out(mc), .cpu_tick_out(cpu), .sys_tick_out(sys));
    osc_model osc_u (.clk_in(mclk), .rst_n_in(rst_n), .period_in(per), .osc_tick_out(osc));
    task end_sim();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // tick tallies, cpu/system pairing and the hang limit; falling edge, where outputs have settled
    always @(negedge mclk)
    begin
        cyc++;
        mc_n += int'(mc);
        cpu_n += int'(cpu);
        if (sys !== cpu)
        begin
            n_errors++;
            $display("MISMATCH t=%0t sys %h cpu %h", $time, sys, cpu);
        end
        if (cyc == 40000)
        begin
            n_errors++;
            end_sim();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // rates from a fractional loop may slip a tick at the window edges
    task near(input int got, input int exp, input int tol);
        chk(32'((got >= exp - tol && got <= exp + tol) ? exp : got), 32'(exp));
    endtask : near
    // one apb transfer, entered just after an edge; an idle edge follows
    // waits for pready as long as it takes; a hang ends at the bench timeout
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        pen <= 1'b1;
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task t_regs();
        apb(1'b0, CFG_OFFSET, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, STATUS_OFFSET, 32'hFFFFFFFF);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd & 32'h3, 32'h0);
        apb(1'b1, 8'h0C, 32'hFFFFFFFF);
        chk(32'(err), 32'h1);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
    endtask : t_regs
    task t_bypass();
        logic [1:0] md [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
        logic [1:0] idv [4] = '{2'h0, 2'h3, 2'h1, 2'h3};
        logic [3:0] odv [4] = '{4'h0, 4'hE, 4'h2, 4'hF};
        int dv [4] = '{1, 60, 6, 60};
        int m0, c0;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, CFG_OFFSET, {24'h0, odv[i], idv[i], md[i]});
            apb(1'b0, CFG_OFFSET, 32'h0);
            chk(rd, {24'h0, (odv[i] == 4'hF) ? 4'hE : odv[i], idv[i], md[i]});
            repeat (240) @(posedge mclk);
            m0 = mc_n;
            c0 = cpu_n;
            repeat (960) @(posedge mclk);
            near(mc_n - m0, 240 / dv[i], 1);
            chk(32'(cpu_n - c0), 32'(mc_n - m0));
        end
    endtask : t_bypass
    task t_halve();
        int m0, c0;
        logic [2:0] tk;
        apb(1'b1, CFG_OFFSET, 32'h0);
        apb(1'b1, SYS_OFFSET, 32'h1);
        repeat (8) @(posedge mclk);
        m0 = mc_n;
        c0 = cpu_n;
        repeat (400) @(posedge mclk);
        near(mc_n - m0, 100, 1);
        near(cpu_n - c0, 50, 1);
        // clock enable low: every tick output must hold its value
        ce <= 1'b0;
        @(posedge mclk);
        tk = {mc, cpu, sys};
        repeat (40)
        begin
            @(posedge mclk);
            chk(32'({mc, cpu, sys}), 32'(tk));
        end
        ce <= 1'b1;
        // reference every cycle gives back-to-back master ticks, halving must skip alternate ones
        per <= 8'h01;
        repeat (8) @(posedge mclk);
        m0 = mc_n;
        c0 = cpu_n;
        repeat (40) @(posedge mclk);
        near(mc_n - m0, 40, 1);
        near(cpu_n - c0, 20, 1);
        // slow reference again; let the period measurement settle before the loop test
        per <= 8'h04;
        repeat (16) @(posedge mclk);
        apb(1'b1, SYS_OFFSET, 32'h0);
    endtask : t_halve
    task t_loop();
        int m0;
        per <= 8'h08;
        apb(1'b1, CFG_OFFSET, 32'h0000_0303);
        repeat (16) @(posedge mclk);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd & 32'h3, 32'h1);
        near(int'(rd[27:16]), 3, 2);
        repeat (200) @(posedge mclk);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd, 32'h0008_0003);
        m0 = mc_n;
        repeat (800) @(posedge mclk);
        near(mc_n - m0, 400, 3);
        apb(1'b1, CFG_OFFSET, 32'h0000_0317);
        repeat (40) @(posedge mclk);
        m0 = mc_n;
        repeat (800) @(posedge mclk);
        near(mc_n - m0, 100, 3);
        // a doubled reference period must be chased step by step
        per <= 8'h10;
        repeat (60) @(posedge mclk);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        near(int'(rd[27:16]), 10, 2);
        apb(1'b1, CFG_OFFSET, 32'h0);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd & 32'h3, 32'h0);
    endtask : t_loop
    // main sequence: reset, then every scenario in turn
    initial
    begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_regs();
        t_bypass();
        t_halve();
        t_loop();
        end_sim();
    end
endmodule : master_clock_generation_tb

//--- dv/osc_model.sv
`timescale 1ns/1ps
// oscillator reference: one-cycle tick every period_in mclk cycles
module osc_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] period_in,
    output logic osc_tick_out
);
    logic [7:0] cnt_q;
    // free running, a crystal never pauses; a shorter period takes effect at once
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt_q <= 8'h00;
            osc_tick_out <= 1'b0;
        end
        else
        begin
            cnt_q <= (cnt_q + 8'h01 >= period_in) ? 8'h00 : cnt_q + 8'h01;
            osc_tick_out <= (cnt_q + 8'h01 >= period_in);
        end
    end
endmodule : osc_model

//--- logic/clock_gen.sv
`timescale 1ns/1ps
module clock_gen
    import clock_gen_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic osc_tick_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic [31:0] prdata_out,
    output logic pslverr_out,
    output logic mc_tick_out,
    output logic cpu_tick_out,
    output logic sys_tick_out
);
    logic rst_meta_q;
    logic rst_n;
    logic pready_q, pready_d;
    logic [31:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;
    logic [MODE_W-1:0] clock_mode_select_q, clock_mode_select_d;
    logic [IDIV_W-1:0] input_prescale_setting_q, input_prescale_setting_d;
    logic [ODIV_W-1:0] output_prescale_setting_q, output_prescale_setting_d;
    logic [MUL_W-1:0] loop_multiplier_setting_q, loop_multiplier_setting_d;
    logic cpu_clock_halve_select_q, cpu_clock_halve_select_d;
    logic setup, access, wr;
    logic [IDIV_W-1:0] in_cnt_q, in_cnt_d;
    logic [ODIV_W-1:0] out_cnt_q, out_cnt_d;
    logic [PER_W-1:0] meas_cnt_q, meas_cnt_d;
    logic [PER_W-1:0] measured_q, measured_d;
    logic [PER_W-1:0] period_est_q, period_est_d;
    logic [DEN_W:0] acc_q, acc_d;
    loop_state_type state_q, state_d;
    logic is_pll, byp_tick, nco_tick;
    logic [DEN_W-1:0] den;
    logic [DEN_W:0] acc_sum, acc_diff;
    logic mc_tick_q, mc_tick_d;
    logic cpu_phase_q, cpu_phase_d;
    logic cpu_tick_q, cpu_tick_d;
    logic sys_tick_q, sys_tick_d;

    // reset release through two flops, assert stays asynchronous
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // apb slave: zero wait states, read data latched in setup
    always_comb
    begin
        setup = psel_in & ~penable_in;
        access = psel_in & penable_in & pready_q;
        wr = access & pwrite_in;
        pready_d = setup;
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        clock_mode_select_d = clock_mode_select_q;
        input_prescale_setting_d = input_prescale_setting_q;
        output_prescale_setting_d = output_prescale_setting_q;
        loop_multiplier_setting_d = loop_multiplier_setting_q;
        cpu_clock_halve_select_d = cpu_clock_halve_select_q;
        if (setup)
        begin
            pslverr_d = 1'b0;
            if (paddr_in == CFG_OFFSET)
                prdata_d = (32'(clock_mode_select_q) << MODE_LSB) | (32'(input_prescale_setting_q) << IDIV_LSB)
                    | (32'(output_prescale_setting_q) << ODIV_LSB) | (32'(loop_multiplier_setting_q) << MUL_LSB);
            else if (paddr_in == SYS_OFFSET)
                prdata_d = 32'(cpu_clock_halve_select_q) << HALVE_BIT;
            else if (paddr_in == STATUS_OFFSET)
                prdata_d = (32'(period_est_q) << PERIOD_LSB) | (32'(state_q) << STATE_LSB);
            else
            begin
                prdata_d = 32'h00000000;
                pslverr_d = 1'b1;
            end
        end
        if (wr && paddr_in == CFG_OFFSET)
        begin
            clock_mode_select_d = pwdata_in[MODE_LSB +: MODE_W];
            input_prescale_setting_d = pwdata_in[IDIV_LSB +: IDIV_W];
            // fifteen is not a legal output divider, so it saturates
            if (pwdata_in[ODIV_LSB +: ODIV_W] > ODIV_MAX)
                output_prescale_setting_d = ODIV_MAX;
            else
                output_prescale_setting_d = pwdata_in[ODIV_LSB +: ODIV_W];
            loop_multiplier_setting_d = pwdata_in[MUL_LSB +: MUL_W];
        end
        if (wr && paddr_in == SYS_OFFSET)
            cpu_clock_halve_select_d = pwdata_in[HALVE_BIT];
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
            clock_mode_select_q <= MODE_RESET;
            input_prescale_setting_q <= IDIV_RESET;
            output_prescale_setting_q <= ODIV_RESET;
            loop_multiplier_setting_q <= MUL_RESET;
            cpu_clock_halve_select_q <= HALVE_RESET;
        end
        else if (ce_in)
        begin
            pready_q <= pready_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
            clock_mode_select_q <= clock_mode_select_d;
            input_prescale_setting_q <= input_prescale_setting_d;
            output_prescale_setting_q <= output_prescale_setting_d;
            loop_multiplier_setting_q <= loop_multiplier_setting_d;
            cpu_clock_halve_select_q <= cpu_clock_halve_select_d;
        end
    end

    // master tick source: prescaler cascade or fractional loop
    always_comb
    begin
        is_pll = (clock_mode_select_q == MODE_PLL);
        byp_tick = 1'b0;
        in_cnt_d = in_cnt_q;
        out_cnt_d = out_cnt_q;
        if (osc_tick_in)
        begin
            if (in_cnt_q >= input_prescale_setting_q)
            begin
                in_cnt_d = '0;
                if (out_cnt_q >= output_prescale_setting_q)
                begin
                    out_cnt_d = '0;
                    byp_tick = 1'b1;
                end
                else
                    out_cnt_d = out_cnt_q + 4'h1;
            end
            else
                in_cnt_d = in_cnt_q + 2'h1;
        end
        // reference period measured in mclk cycles, saturating
        meas_cnt_d = meas_cnt_q;
        measured_d = measured_q;
        if (osc_tick_in)
        begin
            measured_d = meas_cnt_q + 12'h001;
            meas_cnt_d = '0;
        end
        else if (meas_cnt_q != PERIOD_MAX - 12'h001)
            meas_cnt_d = meas_cnt_q + 12'h001;
        // estimate walks one step per reference tick, never jumps
        period_est_d = period_est_q;
        if (is_pll && osc_tick_in)
        begin
            if (period_est_q < measured_q)
                period_est_d = period_est_q + 12'h001;
            else if (period_est_q > measured_q)
                period_est_d = period_est_q - 12'h001;
        end
        state_d = state_q;
        case (state_q)
            ST_BYPASS: if (is_pll) state_d = ST_ACQUIRE;
            ST_ACQUIRE:
                if (!is_pll)
                    state_d = ST_BYPASS;
                else if (period_est_q == measured_q)
                    state_d = ST_LOCKED;
            ST_LOCKED:
                if (!is_pll)
                    state_d = ST_BYPASS;
                else if (period_est_q != measured_q)
                    state_d = ST_ACQUIRE;
            default: state_d = ST_BYPASS;
        endcase
        // tick rate = fmclk*(mul+1)/(est*divs), capped at one per cycle
        den = DEN_W'(period_est_q) * DEN_W'(input_prescale_setting_q + 3'h1)
            * DEN_W'(output_prescale_setting_q + 5'h01);
        acc_sum = acc_q + (DEN_W + 1)'(loop_multiplier_setting_q) + (DEN_W + 1)'(1);
        acc_diff = acc_sum - (DEN_W + 1)'(den);
        nco_tick = 1'b0;
        acc_d = acc_q;
        if (is_pll)
        begin
            acc_d = acc_sum;
            if (acc_sum >= (DEN_W + 1)'(den))
            begin
                nco_tick = 1'b1;
                acc_d = (acc_diff >= (DEN_W + 1)'(den)) ? '0 : acc_diff;
            end
        end
        else
            acc_d = '0;
        mc_tick_d = is_pll ? nco_tick : byp_tick;
        // halving takes every other master tick
        cpu_phase_d = cpu_phase_q;
        if (mc_tick_d && cpu_clock_halve_select_q)
            cpu_phase_d = ~cpu_phase_q;
        cpu_tick_d = mc_tick_d & (~cpu_clock_halve_select_q | cpu_phase_q);
        sys_tick_d = cpu_tick_d;
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_cnt_q <= '0;
            out_cnt_q <= '0;
            meas_cnt_q <= '0;
            measured_q <= PERIOD_RESET;
            period_est_q <= PERIOD_RESET;
            acc_q <= '0;
            state_q <= ST_BYPASS;
            mc_tick_q <= 1'b0;
            cpu_phase_q <= 1'b0;
            cpu_tick_q <= 1'b0;
            sys_tick_q <= 1'b0;
        end
        else if (ce_in)
        begin
            in_cnt_q <= in_cnt_d;
            out_cnt_q <= out_cnt_d;
            meas_cnt_q <= meas_cnt_d;
            measured_q <= measured_d;
            period_est_q <= period_est_d;
            acc_q <= acc_d;
            state_q <= state_d;
            mc_tick_q <= mc_tick_d;
            cpu_phase_q <= cpu_phase_d;
            cpu_tick_q <= cpu_tick_d;
            sys_tick_q <= sys_tick_d;
        end
    end

    assign pready_out = pready_q;
    assign prdata_out = prdata_q;
    assign pslverr_out = pslverr_q;
    assign mc_tick_out = mc_tick_q;
    assign cpu_tick_out = cpu_tick_q;
    assign sys_tick_out = sys_tick_q;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n);
    sequence bypass_wrap_s;
        ce_in && !is_pll && osc_tick_in && in_cnt_q >= input_prescale_setting_q
            && out_cnt_q >= output_prescale_setting_q;
    endsequence
    sequence cfg_write_s;
        ce_in && wr && paddr_in == CFG_OFFSET;
    endsequence
    a_bypass_wrap_tick: assert property (bypass_wrap_s |=> mc_tick_q)
        else $error("bypass wrap gave no master tick");
    a_bypass_needs_osc: assert property ((ce_in && !is_pll && !osc_tick_in) |=> !mc_tick_q)
        else $error("bypass master tick without oscillator tick");
    a_bypass_direct: assert property ((ce_in && !is_pll && osc_tick_in && input_prescale_setting_q == 2'h0
        && output_prescale_setting_q == 4'h0) |=> mc_tick_q)
        else $error("undivided bypass missed an oscillator tick");
    a_odiv_limit: assert property (cfg_write_s |=> output_prescale_setting_q <= ODIV_MAX)
        else $error("output divider above fourteen");
    a_pll_enter: assert property ((ce_in && is_pll && state_q == ST_BYPASS) |=> state_q == ST_ACQUIRE)
        else $error("loop mode did not start acquiring");
    a_loop_tick: assert property ((ce_in && is_pll && acc_sum >= (DEN_W + 1)'(den)) |=> mc_tick_q)
        else $error("loop accumulator overflow gave no tick");
    a_smooth_step: assert property (ce_in |=> (period_est_q == $past(period_est_q)
        || period_est_q == $past(period_est_q) + 12'h001 || period_est_q == $past(period_est_q) - 12'h001))
        else $error("loop period estimate jumped");
    a_cpu_full_rate: assert property ((ce_in && !cpu_clock_halve_select_q && mc_tick_d) |=> cpu_tick_q)
        else $error("cpu tick missing at full rate");
    a_cpu_halved: assert property ((cpu_tick_q && cpu_clock_halve_select_q && ce_in && mc_tick_d
        && $stable(cpu_clock_halve_select_q)) |=> !cpu_tick_q)
        else $error("halved cpu tick on consecutive master ticks");
    a_sys_same_rate: assert property (sys_tick_q == cpu_tick_q)
        else $error("system tick differs from cpu tick");
endmodule : clock_gen

//--- logic/clock_gen_pkg.sv
package clock_gen_pkg;
    // register byte offsets
    localparam logic [7:0] CFG_OFFSET = 8'h00;
    localparam logic [7:0] SYS_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    // field widths
    localparam int MODE_W = 2;
    localparam int IDIV_W = 2;
    localparam int ODIV_W = 4;
    localparam int MUL_W = 5;
    localparam int PER_W = 12;
    localparam int DEN_W = PER_W + IDIV_W + 1 + ODIV_W + 1;
    // field positions in the config, sys and status words
    localparam int MODE_LSB = 0;
    localparam int IDIV_LSB = 2;
    localparam int ODIV_LSB = 4;
    localparam int MUL_LSB = 8;
    localparam int HALVE_BIT = 0;
    localparam int STATE_LSB = 0;
    localparam int PERIOD_LSB = 16;
    // codes, limits and reset values
    localparam logic [MODE_W-1:0] MODE_PLL = 2'h3;
    localparam logic [MODE_W-1:0] MODE_RESET = 2'h0;
    localparam logic [IDIV_W-1:0] IDIV_RESET = 2'h0;
    localparam logic [ODIV_W-1:0] ODIV_RESET = 4'h0;
    localparam logic [ODIV_W-1:0] ODIV_MAX = 4'hE;
    localparam logic [MUL_W-1:0] MUL_RESET = 5'h00;
    localparam logic HALVE_RESET = 1'b0;
    localparam logic [PER_W-1:0] PERIOD_RESET = 12'h001;
    localparam logic [PER_W-1:0] PERIOD_MAX = 12'hFFF;
    // loop state, gray along bypass -> acquire -> locked
    typedef enum logic [1:0] {
        ST_BYPASS = 2'h0,
        ST_ACQUIRE = 2'h1,
        ST_LOCKED = 2'h3
    } loop_state_type;
endpackage : clock_gen_pkg
